// ===== bench/afr_config_props.sv
`timescale 1ns/1ps
`default_nettype none
module afr_config_props (
  // Control
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       sequence_active,
  // Requests
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       bias_wr,
  input wire logic [7:0] bias_wdata,
  input wire logic       src0_wr,
  input wire logic [3:0] src0_wdata,
  input wire logic       raw_valid,
  // Decoded outputs
  input wire logic [1:0] line_filter_select,
  input wire logic [3:0] rate_code,
  input wire logic       external_clock_select,
  input wire logic       pin_zero_override,
  input wire logic [1:0] result_coding,
  input wire logic [7:0] bias_voltage_source,
  input wire logic [3:0] matched_current_source0,
  input wire logic       result_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(a);
    clk_en && reg_wr && reg_addr == a;
  endsequence
  chk_filter_fields: assert property (s_wr(8'h08) |=> {line_filter_select, rate_code} == $past(reg_wdata[5:0]))
    else $error("filter fields wrong");
  chk_clock_write: assert property (s_wr(8'h09) ##0 !sequence_active |=> external_clock_select == $past(reg_wdata[7]))
    else $error("clock select not written");
  chk_clock_frozen: assert property (clk_en && sequence_active |=> $stable(external_clock_select))
    else $error("clock select changed in sequence");
  chk_pin_override: assert property (pin_zero_override == external_clock_select)
    else $error("pin override wrong");
  chk_coding_map: assert property (s_wr(8'h09) |=> result_coding == ($past(reg_wdata[6]) ? 2'h2 : {1'b0, $past(reg_wdata[5])}))
    else $error("coding wrong");
  chk_bias_clears: assert property (clk_en && bias_wr && !src0_wr && matched_current_source0 < 4'h8 && bias_wdata[matched_current_source0[2:0]] |=> matched_current_source0 == 4'hF)
    else $error("source not cleared");
  chk_src_clears: assert property (clk_en && src0_wr && !bias_wr && src0_wdata < 4'h8 |=> !bias_voltage_source[$past(src0_wdata[2:0])])
    else $error("bias not cleared");
  chk_result_pulse: assert property (clk_en |=> result_valid == $past(raw_valid))
    else $error("result pulse wrong");
endmodule // afr_config_props
bind afr_config_regs afr_config_props i_afr_config_props (
  .core_clk                (core_clk),
  .rst_n                   (rst_n),
  .clk_en                  (clk_en),
  .sequence_active         (sequence_active),
  .reg_wr                  (reg_wr),
  .reg_addr                (reg_addr),
  .reg_wdata               (reg_wdata),
  .bias_wr                 (bias_wr),
  .bias_wdata              (bias_wdata),
  .src0_wr                 (src0_wr),
  .src0_wdata              (src0_wdata),
  .raw_valid               (raw_valid),
  .line_filter_select      (line_filter_select),
  .rate_code               (rate_code),
  .external_clock_select   (external_clock_select),
  .pin_zero_override       (pin_zero_override),
  .result_coding           (result_coding),
  .bias_voltage_source     (bias_voltage_source),
  .matched_current_source0 (matched_current_source0),
  .result_valid            (result_valid)
);
`default_nettype wire

// ===== bench/afr_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module afr_config_regs_tb;
  logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, sequence_active = 1'b0;
  logic bias_wr = 1'b0, src0_wr = 1'b0, src1_wr = 1'b0, raw_valid = 1'b0;
  logic [7:0] bias_wdata = 8'h00, d, rv;
  logic [3:0] src0_wdata = 4'h0, src1_wdata = 4'hF;
  logic [25:0] raw_result = 26'h0;
  logic reg_wr, external_clock_select, pin_zero_override, unipolar_select;
  logic ref_pos_buffer_enable, ref_neg_buffer_enable, result_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, bias_voltage_source;
  logic [1:0] line_filter_select, result_coding, bias_voltage_mode, burnout_current_mode;
  logic [3:0] rate_code, excitation_level, matched_current_source0, matched_current_source1;
  logic [2:0] ref_choice;
  logic [23:0] result_data;
  int fails = 0, checked = 0, cycles = 0;
  always #50 core_clk = ~core_clk;
  afr_config_regs i_afr_config_regs (
    .core_clk                (core_clk),
    .rst_n                   (rst_n),
    .clk_en                  (clk_en),
    .reg_wr                  (reg_wr),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_rdata               (reg_rdata),
    .sequence_active         (sequence_active),
    .bias_wr                 (bias_wr),
    .bias_wdata              (bias_wdata),
    .src0_wr                 (src0_wr),
    .src0_wdata              (src0_wdata),
    .src1_wr                 (src1_wr),
    .src1_wdata              (src1_wdata),
    .raw_valid               (raw_valid),
    .raw_result              (raw_result),
    .line_filter_select      (line_filter_select),
    .rate_code               (rate_code),
    .external_clock_select   (external_clock_select),
    .pin_zero_override       (pin_zero_override),
    .unipolar_select         (unipolar_select),
    .result_coding           (result_coding),
    .ref_pos_buffer_enable   (ref_pos_buffer_enable),
    .ref_neg_buffer_enable   (ref_neg_buffer_enable),
    .ref_choice              (ref_choice),
    .bias_voltage_mode       (bias_voltage_mode),
    .burnout_current_mode    (burnout_current_mode),
    .excitation_level        (excitation_level),
    .bias_voltage_source     (bias_voltage_source),
    .matched_current_source0 (matched_current_source0),
    .matched_current_source1 (matched_current_source1),
    .result_valid            (result_valid),
    .result_data             (result_data)
  );
  afr_host_model i_afr_host_model (
    .core_clk  (core_clk),
    .reg_wr    (reg_wr),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata)
  );
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    i_afr_host_model.rd(a, rv);
    chk(rv, e);
  endtask
  task automatic route(input logic b, input logic s, input logic t, input logic [7:0] bd,
                       input logic [3:0] sd, input logic [3:0] td);
    @(posedge core_clk) #1;
    bias_wr = b;
    src0_wr = s;
    src1_wr = t;
    bias_wdata = bd;
    src0_wdata = sd;
    src1_wdata = td;
    @(posedge core_clk) #1;
    bias_wr = 1'b0;
    src0_wr = 1'b0;
    src1_wr = 1'b0;
  endtask
  task automatic conv(input logic [25:0] v, input logic [23:0] e);
    @(posedge core_clk) #1;
    raw_valid = 1'b1;
    raw_result = v;
    @(posedge core_clk) #1;
    raw_valid = 1'b0;
    chk(result_valid, 24'h1);
    chk(result_data, e);
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      results();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    #1 rst_n = 1'b1;
    rdchk(8'h09, 8'h01);
    rdchk(8'h0A, 8'h00);
    rdchk(8'h0B, 8'h00);
    i_afr_host_model.wr(8'h08, 8'hFF);
    rdchk(8'h08, 8'h3F);
    for (int i = 0; i < 4; i++) begin
      i_afr_host_model.wr(8'h08, {2'h0, i[1:0], i[1:0], i[1:0]});
      chk({line_filter_select, rate_code}, {3{i[1:0]}});
    end
    for (int i = 0; i < 8; i++) begin
      d = {i[2:0], i[1:0], i[2:0]};
      i_afr_host_model.wr(8'h09, d);
      chk({external_clock_select, pin_zero_override, unipolar_select}, {d[7], d[7:6]});
      chk(result_coding, d[6] ? 2'h2 : {1'b0, d[5]});
      chk({ref_pos_buffer_enable, ref_neg_buffer_enable, ref_choice}, d[4:0]);
      rdchk(8'h09, d);
    end
    sequence_active = 1'b1;
    i_afr_host_model.wr(8'h09, 8'h01);
    rdchk(8'h09, 8'h81);
    sequence_active = 1'b0;
    for (int i = 0; i < 4; i++) begin
      d = {4{i[1:0]}};
      i_afr_host_model.wr(8'h0A, d);
      chk({bias_voltage_mode, burnout_current_mode, excitation_level}, d);
    end
    route(1'b1, 1'b0, 1'b0, 8'h04, 4'h0, 4'hF);
    route(1'b0, 1'b1, 1'b0, 8'h00, 4'h2, 4'hF);
    chk({bias_voltage_source, matched_current_source0}, 12'h002);
    route(1'b1, 1'b0, 1'b0, 8'h04, 4'h0, 4'hF);
    chk({bias_voltage_source, matched_current_source0}, 12'h04F);
    route(1'b0, 1'b0, 1'b1, 8'h00, 4'h0, 4'h2);
    chk({bias_voltage_source, matched_current_source1}, 12'h002);
    route(1'b1, 1'b0, 1'b0, 8'h04, 4'h0, 4'hF);
    chk({bias_voltage_source, matched_current_source1}, 12'h04F);
    route(1'b1, 1'b1, 1'b0, 8'h08, 4'h3, 4'hF);
    chk({bias_voltage_source, matched_current_source0}, 12'h08F);
    for (int i = 0; i < 3; i++) begin
      i_afr_host_model.wr(8'h09, (i == 0) ? 8'h01 : 8'h01 | (8'h10 << i));
      conv(26'h1000000, (i == 0) ? 24'h7FFFFF : 24'hFFFFFF);
      conv(26'h3000000, (i == 0) ? 24'h800000 : 24'h000000);
      conv(26'h0000005, (i == 1) ? 24'h800005 : 24'h000005);
    end
    rdchk(8'h08, 8'h3F);
    clk_en = 1'b0;
    i_afr_host_model.wr(8'h0A, 8'h00);
    clk_en = 1'b1;
    rdchk(8'h0A, 8'hFF);
    results();
  end
endmodule // afr_config_regs_tb
`default_nettype wire

// ===== bench/afr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module afr_host_model (
  // Register port
  input  wire logic       core_clk,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = (a == 8'h08) ? (v & 8'hBF) : v;
    @(posedge core_clk) #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk) #1;
    reg_addr = a;
    @(posedge core_clk) #1;
    v = reg_rdata;
  endtask
endmodule // afr_host_model
`default_nettype wire

// ===== src/afr_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - line_filter_select 00 dual FIR, 01 50 Hz, 10 60 Hz, 11 sinc4.
// - Four-bit rate code selects data rate, meaning depends on filter select.
// - external_clock_select 0 internal oscillator, 1 clock from pin zero.
// - External clock selected overrides pin_zero_config function.
// - Writes to external_clock_select during a running sequence are ignored.
// - unipolar_select 0 bipolar range, 1 unipolar range.
// - Unipolar range always gives straight binary, format bit ignored.
// - Bipolar range: format 1 offset binary, 0 two's complement.
// - Out-of-range results saturate at min or max code of active format.
// - Reference buffer enables power buffers; clear means bypassed.
// - Reference select picks pairs, supply, or single-ended references.
// - bias_voltage_mode 00 active, 01 125k divider, 1x 20k divider.
// - burnout_current_mode off, 0.5, 1, 10 microamp.
// - excitation_level sets matched source current, 10 to 1600 microamp.
// - Enabling bias on an input clears a matched source on that input.
// - Enabling matched source on an input clears bias on that input, unless a same-cycle bias write enables that input.
module afr_config_regs (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output var  logic [7:0]  reg_rdata,
  // Sequencer status
  input  wire logic        sequence_active,
  // Input mux routing requests
  input  wire logic        bias_wr,
  input  wire logic [7:0]  bias_wdata,
  input  wire logic        src0_wr,
  input  wire logic [3:0]  src0_wdata,
  input  wire logic        src1_wr,
  input  wire logic [3:0]  src1_wdata,
  // Raw conversion result, signed wide
  input  wire logic        raw_valid,
  input  wire logic [25:0] raw_result,
  // Decoded configuration
  output var  logic [1:0]  line_filter_select,
  output var  logic [3:0]  rate_code,
  output var  logic        external_clock_select,
  output var  logic        pin_zero_override,
  output var  logic        unipolar_select,
  output var  logic [1:0]  result_coding,
  output var  logic        ref_pos_buffer_enable,
  output var  logic        ref_neg_buffer_enable,
  output var  logic [2:0]  ref_choice,
  output var  logic [1:0]  bias_voltage_mode,
  output var  logic [1:0]  burnout_current_mode,
  output var  logic [3:0]  excitation_level,
  output var  logic [7:0]  bias_voltage_source,
  output var  logic [3:0]  matched_current_source0,
  output var  logic [3:0]  matched_current_source1,
  // Coded result
  output var  logic        result_valid,
  output var  logic [23:0] result_data
);

  logic [7:0]  filt_reg,  filt_next;
  logic [7:0]  ctrl_reg,  ctrl_next;
  logic [7:0]  exc_reg,   exc_next;
  logic [1:0]  coding_reg, coding_next;
  logic [7:0]  bias_reg,  bias_next;
  logic [3:0]  src0_reg,  src0_next;
  logic [3:0]  src1_reg,  src1_next;
  logic [7:0]  rd_reg,    rd_next;
  logic        rv_reg,    rv_next;
  logic [23:0] res_reg,   res_next;

  // One-hot of the input a source selector drives, zero when off
  function automatic logic [7:0] src_onehot(input logic [3:0] sel);
    logic [7:0] oh;
    oh = 8'h00;
    if (sel < 4'h8) begin
      oh[sel[2:0]] = 1'b1;
    end
    return oh;
  endfunction

  // Result coding from range and format bits
  function automatic logic [1:0] coding_of(input logic [7:0] c);
    logic [1:0] k;
    k = afr_pkg::AFR_CODE_TWOS;
    if (c[afr_pkg::UNIPOLAR_BIT]) begin
      k = afr_pkg::AFR_CODE_STRAIGHT;
    end else if (c[afr_pkg::FORMAT_BIT]) begin
      k = afr_pkg::AFR_CODE_OFFSET;
    end
    return k;
  endfunction

  // Clamp a signed raw result into the 24-bit code of one coding
  function automatic logic [23:0] saturate(input logic signed [25:0] s,
                                           input logic [1:0]         k);
    logic [23:0] r;
    r = s[23:0];
    case (k)
      afr_pkg::AFR_CODE_STRAIGHT: begin
        // Unipolar negatives clamp to zero
        if (s < 26'sh0000000) begin
          r = 24'h000000;
        end else if (s > 26'sh0FFFFFF) begin
          r = 24'hFFFFFF;
        end
      end
      afr_pkg::AFR_CODE_OFFSET: begin
        r = s[23:0] ^ 24'h800000;
        if (s < -26'sh0800000) begin
          r = 24'h000000;
        end else if (s > 26'sh07FFFFF) begin
          r = 24'hFFFFFF;
        end
      end
      default: begin
        if (s < -26'sh0800000) begin
          r = 24'h800000;
        end else if (s > 26'sh07FFFFF) begin
          r = 24'h7FFFFF;
        end
      end
    endcase
    return r;
  endfunction

  // Read-back value of the register at one address
  function automatic logic [7:0] read_back(input logic [7:0] a,
                                           input logic [7:0] f,
                                           input logic [7:0] c,
                                           input logic [7:0] e);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      afr_pkg::ADDR_FILTER_CONFIG: begin
        v = f;
      end
      afr_pkg::ADDR_CONVERSION_CTRL: begin
        v = c;
      end
      afr_pkg::ADDR_EXCITATION_CONFIG: begin
        v = e;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  // Host-written configuration registers
  always_comb begin
    filt_next = filt_reg;
    ctrl_next = ctrl_reg;
    exc_next  = exc_reg;
    if (reg_wr) begin
      case (reg_addr)
        afr_pkg::ADDR_FILTER_CONFIG: begin
          // Bit 7 is never stored
          filt_next = reg_wdata & afr_pkg::FILTER_CONFIG_MASK;
        end
        afr_pkg::ADDR_CONVERSION_CTRL: begin
          ctrl_next = reg_wdata;
          // Clock source must not move while a sequence runs
          if (sequence_active) begin
            ctrl_next[afr_pkg::EXT_CLOCK_BIT] = ctrl_reg[afr_pkg::EXT_CLOCK_BIT];
          end
        end
        afr_pkg::ADDR_EXCITATION_CONFIG: begin
          exc_next = reg_wdata;
        end
        default: begin
        end
      endcase
    end
    coding_next = coding_of(ctrl_next);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_reg   <= afr_pkg::FILTER_CONFIG_RST;
      ctrl_reg   <= afr_pkg::CONVERSION_CTRL_RST;
      exc_reg    <= afr_pkg::EXCITATION_CONFIG_RST;
      coding_reg <= afr_pkg::AFR_CODE_TWOS;
    end else if (clk_en) begin
      filt_reg   <= filt_next;
      ctrl_reg   <= ctrl_next;
      exc_reg    <= exc_next;
      coding_reg <= coding_next;
    end
  end

  // Bias and matched source exclusion, bias write applied last
  always_comb begin
    logic [7:0] oh0;
    logic [7:0] oh1;
    oh0       = 8'h00;
    oh1       = 8'h00;
    bias_next = bias_reg;
    src0_next = src0_reg;
    src1_next = src1_reg;
    // Selectors 8 and up never collide with bias
    if (src0_wr) begin
      src0_next = src0_wdata;
      bias_next = bias_next & ~src_onehot(src0_wdata);
    end
    if (src1_wr) begin
      src1_next = src1_wdata;
      bias_next = bias_next & ~src_onehot(src1_wdata);
    end
    if (bias_wr) begin
      bias_next = bias_wdata;
      oh0 = src_onehot(src0_next);
      oh1 = src_onehot(src1_next);
      if ((oh0 & bias_wdata) != 8'h00) begin
        src0_next = afr_pkg::SOURCE_SEL_OFF;
      end
      if ((oh1 & bias_wdata) != 8'h00) begin
        src1_next = afr_pkg::SOURCE_SEL_OFF;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bias_reg <= afr_pkg::BIAS_ENABLE_RST;
      src0_reg <= afr_pkg::SOURCE_SEL_OFF;
      src1_reg <= afr_pkg::SOURCE_SEL_OFF;
    end else if (clk_en) begin
      bias_reg <= bias_next;
      src0_reg <= src0_next;
      src1_reg <= src1_next;
    end
  end

  // Result coded with the coding in force at the sample
  always_comb begin
    rv_next  = raw_valid;
    res_next = res_reg;
    if (raw_valid) begin
      res_next = saturate(signed'(raw_result), coding_reg);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rv_reg  <= afr_pkg::VALID_RST;
      res_reg <= afr_pkg::RESULT_RST;
    end else if (clk_en) begin
      rv_reg  <= rv_next;
      res_reg <= res_next;
    end
  end

  // Registered read-back, one cycle behind the address
  always_comb begin
    rd_next = read_back(reg_addr, filt_reg, ctrl_reg, exc_reg);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_reg <= afr_pkg::RDATA_RST;
    end else if (clk_en) begin
      rd_reg <= rd_next;
    end
  end

  // Decoded fields, straight from the register flops
  always_comb begin
    reg_rdata               = rd_reg;
    line_filter_select      = filt_reg[afr_pkg::LINE_FILTER_LSB +: 2];
    rate_code               = filt_reg[afr_pkg::RATE_LSB +: 4];
    // Clock source and pin zero override share bit 7
    external_clock_select   = ctrl_reg[afr_pkg::EXT_CLOCK_BIT];
    pin_zero_override       = ctrl_reg[afr_pkg::EXT_CLOCK_BIT];
    unipolar_select         = ctrl_reg[afr_pkg::UNIPOLAR_BIT];
    result_coding           = coding_reg;
    ref_pos_buffer_enable   = ctrl_reg[afr_pkg::REF_POS_BUF_BIT];
    ref_neg_buffer_enable   = ctrl_reg[afr_pkg::REF_NEG_BUF_BIT];
    ref_choice              = ctrl_reg[afr_pkg::REF_SEL_LSB +: 3];
    bias_voltage_mode       = exc_reg[afr_pkg::BIAS_MODE_LSB +: 2];
    burnout_current_mode    = exc_reg[afr_pkg::BURNOUT_LSB +: 2];
    excitation_level        = exc_reg[afr_pkg::EXC_LEVEL_LSB +: 4];
    bias_voltage_source     = bias_reg;
    matched_current_source0 = src0_reg;
    matched_current_source1 = src1_reg;
    result_valid            = rv_reg;
    result_data             = res_reg;
  end

endmodule // afr_config_regs
`default_nettype wire

// ===== src/afr_pkg.sv
package afr_pkg;
  // Register addresses on the serial control port
  localparam logic [7:0] ADDR_FILTER_CONFIG     = 8'h08;
  localparam logic [7:0] ADDR_CONVERSION_CTRL   = 8'h09;
  localparam logic [7:0] ADDR_EXCITATION_CONFIG = 8'h0A;
  // Reset values
  localparam logic [7:0] FILTER_CONFIG_RST     = 8'h00;
  localparam logic [7:0] CONVERSION_CTRL_RST   = 8'h01;
  localparam logic [7:0] EXCITATION_CONFIG_RST = 8'h00;
  localparam logic [7:0] BIAS_ENABLE_RST       = 8'h00;
  localparam logic [3:0] SOURCE_SEL_OFF        = 4'hF;
  localparam logic [7:0] RDATA_RST             = 8'h00;
  localparam logic       VALID_RST             = 1'b0;
  localparam logic [23:0] RESULT_RST           = 24'h000000;
  // Field positions
  localparam int FILTER_RESERVED_BIT = 6;
  localparam int LINE_FILTER_LSB     = 4;
  localparam int RATE_LSB            = 0;
  localparam int EXT_CLOCK_BIT       = 7;
  localparam int UNIPOLAR_BIT        = 6;
  localparam int FORMAT_BIT          = 5;
  localparam int REF_POS_BUF_BIT     = 4;
  localparam int REF_NEG_BUF_BIT     = 3;
  localparam int REF_SEL_LSB         = 0;
  localparam int BIAS_MODE_LSB       = 6;
  localparam int BURNOUT_LSB         = 4;
  localparam int EXC_LEVEL_LSB       = 0;
  // Implemented bits per register
  localparam logic [7:0] FILTER_CONFIG_MASK = 8'h7F;
  // Result coding
  typedef enum logic [1:0] {
    AFR_CODE_TWOS, AFR_CODE_OFFSET, AFR_CODE_STRAIGHT
  } afr_coding_e;
  // Reference choice
  typedef enum logic [2:0] {
    AFR_REF_PAIR0, AFR_REF_PAIR1, AFR_REF_PAIR2, AFR_REF_SUPPLY,
    AFR_REF_SE0, AFR_REF_SE1, AFR_REF_SE2
  } afr_ref_e;
endpackage
